// >>> dv/pwm_pullup_model.sv
`timescale 1ns/1ps
// external pull-ups ahead of the rc filters
module pwm_pullup_model (
   // pins from the device
   input wire logic [7:0] oe_n_i,
   input wire logic [7:0] out_i,
   // line levels seen by the filters
   output logic [7:0] line_o
);
   // a released pin is lifted by its resistor, so it never shows a stale value
   assign line_o = oe_n_i | out_i;
endmodule : pwm_pullup_model

// >>> dv/tb.sv
`timescale 1ns/1ps
`include "pwm_dac_map.svh"
module tb;
   import pwm_dac_pkg::*;
   logic clk_sys_i = 1'b0, nrst_i = 1'b0, pix = 1'b1, hfl = 1'b0, ht = 1'b0;
   reg_write_s wr_i = '0;
   logic [7:0] oe_n, od, ln;
   logic mck;
   logic [1:0] rr;
   logic [31:0] q[$], got, ev;
   string nm;
   int failures = 0, comparisons = 0, p0, p, h, d;
   duty_t dl[8];
   event got_ev;
   // 40 MHz clock
   always #12.5 clk_sys_i = ~clk_sys_i;
   eight_channel_pwm_dac uut(.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pixel_en_i(pix),
      .horizontal_flyback_in_i(hfl), .wr_i(wr_i), .halftone_out_i(ht),
      .modulated_out_oe_n_o(oe_n), .modulated_out_o(od), .modulator_clock_o(mck), .rate_range_o(rr));
   pwm_pullup_model pu(.oe_n_i(oe_n), .out_i(od), .line_o(ln));
   // monitor: oldest expectation against each reported result
   always @(got_ev) begin
      ev = q.pop_front();
      comparisons++;
      if (got !== ev) begin
         failures++;
         $display("[ERR] %s expected %0d seen %0d", nm, ev, got);
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      q.push_back(e);
      nm = n;
      got = g;
      ->got_ev;
      #1;
   endtask : chk
   task automatic wr(input logic [4:0] c, input logic [7:0] v, input logic [3:0] r = `DUTY_ROW);
      @(negedge clk_sys_i);
      wr_i = '{1'b1, r, c, v};
      @(negedge clk_sys_i);
      wr_i.en = 1'b0;
   endtask : wr
   // counts cycles up to the next rising edge; stops at 9000 if none comes
   task automatic rise(input int c, inout int n);
      bit a;
      a = ln[c];
      repeat (9000) begin
         @(negedge clk_sys_i);
         n++;
         if (ln[c] && !a) return;
         a = ln[c];
      end
   endtask : rise
   // one full period from rise to rise, with its released cycles
   task automatic meas(input int c, output int pp, output int hh);
      bit a;
      a = 1'b1;
      pp = 0;
      hh = 0;
      // first rise may be a partial period right after a duty write
      rise(c, pp);
      rise(c, pp);
      pp = 0;
      repeat (9000) begin
         hh += ln[c];
         pp++;
         @(negedge clk_sys_i);
         if (ln[c] && !a) break;
         a = ln[c];
      end
   endtask : meas
   task final_report;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   // main sequence
   initial begin
      void'($urandom(32'h2962));
      repeat (8) @(negedge clk_sys_i);
      nrst_i = 1'b1;
      chk("range_rst", 0, rr);
      for (int c = 0; c < 8; c++) wr(5'(`DUTY_COL_FIRST + c), 8'h80);
      for (int r = 0; r < 4; r++) begin
         wr(`OPTION_COL, 8'(r));
         meas(0, p, h);
         if (r == 0) p0 = p;
         chk("range_rb", r, rr);
         chk("period", p0 << r, p);
      end
      chk("period_256", 0, p0 % 256);
      wr(`OPTION_COL, 8'h21);
      for (int c = 0; c < 8; c++) begin
         dl[c] = 8'($urandom_range(255, 1));
         wr(5'(`DUTY_COL_FIRST + c), dl[c]);
         meas(c, p, h);
         chk("duty", dl[c] * p, h * 256);
      end
      for (int c = 0; c < 7; c++) begin
         d = 0;
         rise(c, d);
         d = 0;
         rise(c + 1, d);
         chk("stagger", p / 512, d);
      end
      d = 0;
      repeat (p) begin
         @(negedge clk_sys_i);
         d += mck;
      end
      chk("clk_high", p / 2, d);
      wr(`OPTION_COL, 8'h00);
      ht = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      chk("halftone", 1, mck);
      hfl = 1'b1;
      @(negedge clk_sys_i);
      hfl = 1'b0;
      wr(`DUTY_COL_FIRST, 8'h00, 4'he);
      wr(5'h1b, 8'h00);
      meas(0, p, h);
      chk("ignored", dl[0] * p, h * 256);
      wr(`DUTY_COL_FIRST, 8'h00);
      d = 0;
      rise(0, d);
      chk("duty_zero", 9000, d);
      chk("od_low", 0, od);
      final_report;
   end
   // watchdog well beyond the expected run
   initial begin
      #1500000;
      failures++;
      final_report;
   end
endmodule : tb

// >>> hdl/eight_channel_pwm_dac.sv
`timescale 1ns/1ps
`include "pwm_dac_map.svh"
// Overview of operation
// [RULE_01] eight open-drain outputs, pull low or release
// [RULE_02] duty byte gives duty/256 of period
// [RULE_03] row 15 columns 19-26 set channels
// [RULE_04] range field sets period of all channels
// [RULE_05] rising edges staggered by half modulator clock; range 00 instead steps each even/odd channel pair together
// [RULE_06] clock divided 1,2,4,8; rate clock/256
// [RULE_07] option bit drives clock pin, 50 percent
// [RULE_08] free counter; active below duty value
module eight_channel_pwm_dac #(
   parameter int CHANNELS = 8
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // pixel clock enable (one pulse per pixel) and flyback
   input wire logic pixel_en_i,
   input wire logic horizontal_flyback_in_i,
   // register writes from the serial interface
   input wire pwm_dac_pkg::reg_write_s wr_i,
   // halftone source for the shared pin
   input wire logic halftone_out_i,
   // open-drain channel pins, low enable = pulling low
   output logic [CHANNELS-1:0] modulated_out_oe_n_o,
   output logic [CHANNELS-1:0] modulated_out_o,
   // shared clock / halftone pin
   output logic modulator_clock_o,
   // state readback
   output logic [1:0] rate_range_o
);
   import pwm_dac_pkg::*;

   duty_t duty_ff [CHANNELS];
   range_t range_ff;
   logic clksel_ff;
   logic [2:0] div_ff;
   logic flb_ff;
   logic half_ff;
   logic [7:0] count_ff;
   logic pin_ff;
   logic [1:0] range_out_ff;
   logic [CHANNELS-1:0] zero_ff;

   // write decode
   wire row_hit = wr_i.en && (wr_i.row == `DUTY_ROW);
   wire opt_hit = row_hit && (wr_i.col == `OPTION_COL);
   wire duty_hit = row_hit && (wr_i.col >= `DUTY_COL_FIRST) && (wr_i.col <= `DUTY_COL_LAST); // RULE_03
   wire [4:0] duty_idx = wr_i.col - `DUTY_COL_FIRST;

   // divider terminal count per range; half-clock event at every pixel step of the ratio/2
   wire flb_rise = horizontal_flyback_in_i & ~flb_ff;
   logic [2:0] div_last;
   always_comb begin
      case (range_ff) // RULE_06
         RANGE_DIV1: div_last = 3'h0;
         RANGE_DIV2: div_last = 3'h1;
         RANGE_DIV4: div_last = 3'h3;
         RANGE_DIV8: div_last = 3'h7;
         default: div_last = 3'h0;
      endcase
   end
   // a half-period tick: for div1 every pixel (pixel half handled as one step, limitation)
   wire [2:0] half_last = (div_last == 3'h0) ? 3'h0 : (div_last >> 1);
   wire div_wrap = pixel_en_i && (div_ff == div_last);
   wire half_tick = pixel_en_i && ((div_ff == half_last) || (div_ff == div_last)); // RULE_04
   // range 00 cannot split a pixel: counter and all channels step on every pixel instead
   wire div1 = (range_ff == RANGE_DIV1); // RULE_06

   // registers written by host
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         range_ff <= `RANGE_RESET;
         clksel_ff <= `CLKSEL_RESET;
      end else if (opt_hit) begin
         range_ff <= {wr_i.data[`OPTION_RANGE_HI_BIT], wr_i.data[`OPTION_RANGE_LO_BIT]};
         clksel_ff <= wr_i.data[`OPTION_CLKSEL_BIT];
      end
   end
   for (genvar g = 0; g < CHANNELS; g++) begin : g_duty
      always_ff @(posedge clk_sys_i) begin
         if (!nrst_i) duty_ff[g] <= `DUTY_RESET;
         else if (duty_hit && duty_idx == 5'(g)) duty_ff[g] <= wr_i.data; // RULE_03
      end
   end

   // divider restarts on flyback so the clock pin stays locked to it
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         div_ff <= 3'h0;
         flb_ff <= 1'b0;
      end else begin
         flb_ff <= horizontal_flyback_in_i;
         if (flb_rise) div_ff <= 3'h0; // RULE_07
         else if (opt_hit) div_ff <= 3'h0; // RULE_04
         else if (div_wrap) div_ff <= 3'h0;
         else if (pixel_en_i) div_ff <= div_ff + 3'h1;
      end
   end

   // shared free counter of 256 steps; half_ff marks second half of a modulator clock
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         count_ff <= 8'h00;
         half_ff <= 1'b0;
      end else if (half_tick) begin
         half_ff <= ~half_ff;
         if (half_ff || div1) count_ff <= count_ff + 8'h01; // RULE_08
      end
   end

   // outside range 00, channel n sees count shifted by n/2 clocks: even by n/2 whole steps, odd on opposite half
   for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      wire [7:0] ch_count = count_ff - 8'(c / 2); // RULE_05
      wire ch_step = half_tick && (div1 || (half_ff == 1'(c % 2))); // RULE_05
      logic oe_n;
      pwm_channel #(.WIDTH(8)) u_ch (
         .clk_sys_i(clk_sys_i),
         .nrst_i(nrst_i),
         .step_i(ch_step),
         .count_i(ch_count),
         .duty_i(duty_ff[c]), // RULE_02
         .pull_low_oe_n_o(oe_n)
      );
      assign modulated_out_oe_n_o[c] = oe_n; // RULE_01
      // active phase releases the line; otherwise pull low
      always_ff @(posedge clk_sys_i) begin
         if (!nrst_i) zero_ff[c] <= 1'b0;
         else zero_ff[c] <= 1'b0;
      end
      assign modulated_out_o[c] = zero_ff[c]; // RULE_01
   end

   // shared pin: 50 percent clock or halftone
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         pin_ff <= 1'b0;
         range_out_ff <= `RANGE_RESET;
      end else begin
         range_out_ff <= range_ff;
         pin_ff <= clksel_ff ? ~half_ff : halftone_out_i; // RULE_07
      end
   end
   assign modulator_clock_o = pin_ff;
   assign rate_range_o = range_out_ff;

   // step and write events used by the checks below
   sequence s_count_step;
      half_tick && (half_ff || div1);
   endsequence
   sequence s_ch0_zero_step;
      (duty_ff[0] == 8'h00) [*2] ##0 g_ch[0].ch_step;
   endsequence
   sequence s_ch2_full_step;
      duty_ff[2] == 8'hff && half_tick && half_ff == 1'b0 && count_ff == 8'h05;
   endsequence
   sequence s_opt_write;
      opt_hit;
   endsequence
   sequence s_other_row;
      wr_i.en && (wr_i.row != `DUTY_ROW);
   endsequence
   // period start of channel 0; range 00 is left out since its channels share a step
   sequence s_ch0_period_start;
      $rose(modulated_out_oe_n_o[0]) && count_ff == 8'h00 && !div1;
   endsequence

   // write to a duty column lands next cycle
   property p_duty_write;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (duty_hit && duty_idx == 5'h0) |=> (duty_ff[0] == $past(wr_i.data));
   endproperty
   AST_DUTY_WRITE: assert property (p_duty_write) else $error("duty 0 not written"); // RULE_03

   // zero duty: line held low from the next channel step on
   property p_zero_duty;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_ch0_zero_step |=> !modulated_out_oe_n_o[0];
   endproperty
   AST_ZERO_DUTY: assert property (p_zero_duty) else $error("zero duty pulsed"); // RULE_08

   // full duty: released early in the period
   property p_full_duty;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_ch2_full_step |=> modulated_out_oe_n_o[2];
   endproperty
   AST_FULL_DUTY: assert property (p_full_duty) else $error("high duty inactive"); // RULE_02

   // divider never runs past the terminal count of the selected range
   AST_DIV_RANGE: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      div_ff <= div_last || $past(range_ff) != range_ff) else $error("divider overrun"); // RULE_06

   // readback copy follows the option write two edges later
   property p_range_out;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_opt_write |=> ##1 rate_range_o == {$past(wr_i.data[1], 2), $past(wr_i.data[0], 2)};
   endproperty
   AST_RANGE_OUT: assert property (p_range_out) else $error("range not applied"); // RULE_04

   // a new range restarts the divider so no stale count outlives it
   property p_range_restart;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_opt_write |=> div_ff == 3'h0;
   endproperty
   AST_RANGE_RESTART: assert property (p_range_restart) else $error("divider not restarted"); // RULE_04

   // flyback edge realigns the divider
   AST_FLB_RESTART: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      flb_rise |=> div_ff == 3'h0) else $error("flyback not locked"); // RULE_07

   // clock pin carries the inverted half-period phase
   AST_CLK_PIN: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      (clksel_ff && $past(clksel_ff)) |-> modulator_clock_o == ~$past(half_ff)) else $error("clock pin wrong"); // RULE_07

   // outside range 00, channel 1 has not risen yet when channel 0 starts its period
   property p_stagger;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_ch0_period_start |-> !modulated_out_oe_n_o[1];
   endproperty
   AST_STAGGER: assert property (p_stagger) else $error("stagger phase"); // RULE_05

   // counter advances by one on each counting step
   property p_count_step;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_count_step |=> count_ff == 8'($past(count_ff) + 8'h01);
   endproperty
   AST_COUNT_STEP: assert property (p_count_step) else $error("counter skipped"); // RULE_08

   // counter holds between half-period ticks
   AST_COUNT_HOLD: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      !half_tick |=> $stable(count_ff)) else $error("counter moved off tick"); // RULE_06

   // writes to other rows leave duty byte 0 alone
   property p_other_row;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_other_row |=> duty_ff[0] == $past(duty_ff[0]);
   endproperty
   AST_OTHER_ROW: assert property (p_other_row) else $error("foreign row written"); // RULE_03

   // open-drain value is always low
   AST_OD_LOW: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      modulated_out_o == '0) else $error("open drain drives high"); // RULE_01
endmodule : eight_channel_pwm_dac

// >>> hdl/pwm_channel.sv
`timescale 1ns/1ps
// one modulator channel: counter phase-shifted per channel, open-drain output
module pwm_channel #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // timing
   input wire logic step_i,
   input wire logic [WIDTH-1:0] count_i,
   input wire logic [WIDTH-1:0] duty_i,
   // pin
   output logic pull_low_oe_n_o
);
   logic nxt_oe_n;
   // active while count below duty releases the line; zero duty stays pulled low
   assign nxt_oe_n = (count_i < duty_i);
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) pull_low_oe_n_o <= 1'b1;
      else if (step_i) pull_low_oe_n_o <= nxt_oe_n;
   end
endmodule : pwm_channel

// >>> pkg/pwm_dac_map.svh
`ifndef PWM_DAC_MAP_SVH
`define PWM_DAC_MAP_SVH
// control-byte row and column placement of the duty bytes
`define DUTY_ROW 4'hf
`define DUTY_COL_FIRST 5'h13
`define DUTY_COL_LAST 5'h1a
// column holding the option bits, and their positions
`define OPTION_COL 5'h12
`define OPTION_CLKSEL_BIT 5
`define OPTION_RANGE_HI_BIT 1
`define OPTION_RANGE_LO_BIT 0
// reset values
`define DUTY_RESET 8'h00
`define RANGE_RESET 2'h0
`define CLKSEL_RESET 1'b0
// modulation period in modulator clocks
`define PWM_STEPS 256
`endif

// >>> pkg/pwm_dac_pkg.sv
package pwm_dac_pkg;
   typedef logic [7:0] duty_t;
   typedef logic [1:0] range_t;
   // one register write from the serial interface
   typedef struct packed {
      logic       en;
      logic [3:0] row;
      logic [4:0] col;
      logic [7:0] data;
   } reg_write_s;
   typedef enum logic [1:0] {
      RANGE_DIV1 = 2'b00,
      RANGE_DIV2 = 2'b01,
      RANGE_DIV4 = 2'b10,
      RANGE_DIV8 = 2'b11
   } range_e;
endpackage : pwm_dac_pkg
